// ---- src/tgs_pkg.sv ----
package tgs_pkg;
  // ------------------------------------------------------------
  // Register word addresses (16-bit words, low byte = offset 0)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_REF_CFG = 8'h87;
  localparam logic [7:0] REG_BLOCK = 8'h88;
  localparam logic [7:0] REG_SLIDER = 8'h89;
  localparam logic [7:0] REG_GEST_TO = 8'h8a;
  localparam logic [7:0] REG_SWIPE_CMD = 8'h8b;
  localparam logic [7:0] REG_LINK_CTRL = 8'hf2;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TRACK_EN_BIT = 15;
  localparam int RESEED_LVL_LSB = 11;
  localparam int FILT_LSB = 8;
  localparam int END_WIN_BIT = 7;
  localparam int STOP_DIS_BIT = 6;
  localparam int RO_DIS_BIT = 5;
  localparam int SLEEP_BIT = 4;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_CMD_MASK = 8'h00;
  localparam logic [1:0] RST_TWO = 2'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int GEST_STEP_MS = 16;
  localparam int GEST_STEP_CYC = GEST_STEP_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] TIMER_MAX = 8'hff;
endpackage : tgs_pkg

// ---- src/tgs_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Reference trigger reseeds associated channels whose state lies within the level.
// - Tracking enabled disables the default reference reseed.
// - Tracking does nothing for associated channels without proximity or touch.
// - Reference long-term average frozen while an associated channel is active.
// - Weighted reference delta subtracted from active associated channel averages.
// - Two-bit filter smooths coordinates for swipe only; tap uses raw coordinate.
// - Eight-bit mask marks blocking channels, bit n for channel n.
// - Lone changes reported depending on partner channel proximity.
// - Blocking and associated channel changing together reports nothing.
// - Two sliders, each with an eight-bit channel membership mask.
// - Tap accepted only if completed within tap timeout, 16 ms steps.
// - Tap rejected if coordinate change exceeds half the swipe threshold.
// - Swipe recognised only if completed below swipe timeout.
// - Swipe recognised only if coordinate change exceeds threshold.
// - Command mask alone reseeds the selected channels.
// - Mask plus retune command in one window retunes instead of reseeding.
// - Command mask resets to all zeros.
// - Reseed leaving average outside band starts retune automatically.
// - End-window bit closes the communication window.
// - Disable-stop bit stops STOP condition recognition.
module tgs_ctrl #(
  parameter int TICK_CYC = tgs_pkg::GEST_STEP_CYC // Cycles per 16 ms step
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic wr_en, // Register write strobe
  input wire logic rd_en, // Register read strobe
  input wire logic [7:0] reg_addr, // Register word address
  input wire logic [15:0] wr_data, // Write word
  output logic [15:0] rd_data, // Read word
  input wire logic win_open, // Communication window open
  input wire logic retune_cmd, // Retune command bit
  input wire logic sample_tick, // New sample strobe
  input wire logic ref_trig, // Reference threshold crossing
  input wire logic [7:0] ref_assoc, // Channels tied to reference
  input wire logic [7:0] ch_prox, // Proximity states
  input wire logic [7:0] ch_touch, // Touch states
  input wire logic [7:0] ch_deep, // Deep touch states
  input wire logic [7:0] ch_change, // State changed this sample
  input wire logic [7:0] avg_out_band, // Average outside band
  input wire logic [7:0] coord0, // Slider 0 coordinate
  input wire logic [7:0] coord1, // Slider 1 coordinate
  output logic [7:0] reseed_req, // Reseed pulses
  output logic [7:0] retune_req, // Retune pulses
  output logic ref_avg_freeze, // Hold reference average
  output logic [7:0] track_sub_en, // Subtract weighted delta
  output logic [7:0] event_rpt, // Reported events
  output logic [1:0] tap_det, // Tap pulses
  output logic [1:0] swipe_det, // Swipe pulses
  output logic window_end, // Close window pulse
  output logic stop_det_dis, // Ignore STOP condition
  output logic ro_write_en, // Allow read-only writes
  output logic sleep_in_win // Sleep during window
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction : abs_diff

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic track_en_q;
  logic [1:0] reseed_lvl_q;
  logic [1:0] filt_q;
  logic [7:0] block_mask_q;
  logic [7:0] slider_mask_q [2];
  logic [7:0] tap_to_q;
  logic [7:0] swipe_to_q;
  logic [7:0] swipe_thr_q;
  logic [7:0] cmd_mask_q;
  logic [7:0] link_ctrl_q;
  logic cmd_retune_q;
  logic win_open_q;

  // Write decode
  wire wr_ref = wr_en && reg_addr == tgs_pkg::REG_REF_CFG;
  wire wr_blk = wr_en && reg_addr == tgs_pkg::REG_BLOCK;
  wire wr_sld = wr_en && reg_addr == tgs_pkg::REG_SLIDER;
  wire wr_gto = wr_en && reg_addr == tgs_pkg::REG_GEST_TO;
  wire wr_swc = wr_en && reg_addr == tgs_pkg::REG_SWIPE_CMD;
  wire wr_lnk = wr_en && reg_addr == tgs_pkg::REG_LINK_CTRL;

  // Window closes by end-window command or by the link dropping it
  wire end_cmd = wr_lnk && wr_data[tgs_pkg::END_WIN_BIT];
  wire win_close = end_cmd || (win_open_q && !win_open);

  // Read mux; unmapped words and reserved bits read zero
  wire [15:0] ref_word = {track_en_q, 1'b0, 1'b0, reseed_lvl_q, 1'b0, filt_q, 8'h00};
  wire [15:0] rd_mux =
    (reg_addr == tgs_pkg::REG_REF_CFG) ? ref_word :
    (reg_addr == tgs_pkg::REG_BLOCK) ? {8'h00, block_mask_q} :
    (reg_addr == tgs_pkg::REG_SLIDER) ? {slider_mask_q[1], slider_mask_q[0]} :
    (reg_addr == tgs_pkg::REG_GEST_TO) ? {swipe_to_q, tap_to_q} :
    (reg_addr == tgs_pkg::REG_SWIPE_CMD) ? {cmd_mask_q, swipe_thr_q} :
    (reg_addr == tgs_pkg::REG_LINK_CTRL) ? {8'h00, link_ctrl_q} : 16'h0000;

  // Configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      track_en_q <= 1'b0;
      reseed_lvl_q <= tgs_pkg::RST_TWO;
      filt_q <= tgs_pkg::RST_TWO;
      block_mask_q <= tgs_pkg::RST_BYTE;
      slider_mask_q[0] <= tgs_pkg::RST_BYTE;
      slider_mask_q[1] <= tgs_pkg::RST_BYTE;
      tap_to_q <= tgs_pkg::RST_BYTE;
      swipe_to_q <= tgs_pkg::RST_BYTE;
      swipe_thr_q <= tgs_pkg::RST_BYTE;
      link_ctrl_q <= tgs_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_ref)
      begin
        track_en_q <= wr_data[tgs_pkg::TRACK_EN_BIT];
        reseed_lvl_q <= wr_data[tgs_pkg::RESEED_LVL_LSB +: 2];
        filt_q <= wr_data[tgs_pkg::FILT_LSB +: 2];
      end
      if (wr_blk)
        block_mask_q <= wr_data[7:0];
      if (wr_sld)
      begin
        slider_mask_q[0] <= wr_data[7:0];
        slider_mask_q[1] <= wr_data[15:8];
      end
      if (wr_gto)
      begin
        tap_to_q <= wr_data[7:0];
        swipe_to_q <= wr_data[15:8];
      end
      if (wr_swc)
        swipe_thr_q <= wr_data[7:0];
      // Whole byte stored; end bit is left for the host to clear
      if (wr_lnk)
        link_ctrl_q <= wr_data[7:0];
    end
  end

  // ------------------------------------------------------------
  // Reseed and retune commands
  // ------------------------------------------------------------
  wire [7:0] lvl_ok =
    (reseed_lvl_q == 2'h0) ? ~(ch_prox | ch_touch | ch_deep) :
    (reseed_lvl_q == 2'h1) ? ~(ch_touch | ch_deep) :
    (reseed_lvl_q == 2'h2) ? ~ch_deep : 8'hff;
  wire [7:0] ref_reseed = (ref_trig && !track_en_q) ? (ref_assoc & lvl_ok) : 8'h00;
  wire do_cmd = win_close && cmd_mask_q != 8'h00;
  wire [7:0] cmd_reseed = (do_cmd && !cmd_retune_q) ? cmd_mask_q : 8'h00;
  wire [7:0] cmd_retune = (do_cmd && cmd_retune_q) ? cmd_mask_q : 8'h00;
  wire [7:0] auto_retune = reseed_req & avg_out_band;

  // Command mask acts once at window close, then clears
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cmd_mask_q <= tgs_pkg::RST_CMD_MASK;
      cmd_retune_q <= 1'b0;
      win_open_q <= 1'b0;
      reseed_req <= 8'h00;
      retune_req <= 8'h00;
    end
    else
    begin
      win_open_q <= win_open;
      if (wr_swc)
        cmd_mask_q <= wr_data[15:8];
      else if (win_close)
        cmd_mask_q <= 8'h00;
      // Set wins; a command landing on the close is kept for the next window
      if (retune_cmd)
        cmd_retune_q <= 1'b1;
      else if (win_close)
        cmd_retune_q <= 1'b0;
      reseed_req <= ref_reseed | cmd_reseed;
      retune_req <= cmd_retune | auto_retune;
    end
  end

  // ------------------------------------------------------------
  // Tracking and event blocking
  // ------------------------------------------------------------
  wire [7:0] assoc_act = ref_assoc & (ch_prox | ch_touch);
  wire [7:0] assoc_only = ref_assoc & ~block_mask_q;
  wire blk_chg = |(ch_change & block_mask_q);
  wire blk_prox = |(ch_prox & block_mask_q);
  wire asc_chg = |(ch_change & assoc_only);
  wire asc_prox = |(ch_prox & assoc_only);
  // Only one side may move; a joint move is swallowed
  wire [7:0] asc_ok = (!blk_chg && !blk_prox) ? assoc_only : 8'h00;
  wire [7:0] blk_ok = (!asc_chg && asc_prox) ? block_mask_q : 8'h00;
  wire [7:0] free_ch = ~(assoc_only | block_mask_q);
  wire [7:0] rpt = ch_change & (free_ch | asc_ok | blk_ok);

  // Sample-aligned event output; tracking outputs update every cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ref_avg_freeze <= 1'b0;
      track_sub_en <= 8'h00;
      event_rpt <= 8'h00;
    end
    else
    begin
      ref_avg_freeze <= track_en_q && |assoc_act;
      track_sub_en <= track_en_q ? assoc_act : 8'h00;
      event_rpt <= sample_tick ? rpt : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Gesture timing
  // ------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  wire step = tick_cnt_q == 32'(TICK_CYC - 1);

  // 16 ms step generator; long count kept as a parameter for sims
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= step ? 32'h0 : tick_cnt_q + 32'h1;
  end

  logic [1:0] held_q;
  logic [7:0] timer_q [2];
  logic [7:0] start_raw_q [2];
  logic [7:0] start_flt_q [2];
  logic [7:0] last_raw_q [2];
  logic [7:0] flt_q [2];
  wire [7:0] coord [2];
  wire [1:0] active;
  wire [7:0] flt_nx [2];
  wire [1:0] rel;
  wire [1:0] tap_ok;
  wire [1:0] swp_ok;
  assign coord[0] = coord0;
  assign coord[1] = coord1;

  // Per-slider decode
  for (genvar s = 0; s < 2; s++)
  begin : g_sld
    wire [8:0] diff = {1'b0, coord[s]} - {1'b0, flt_q[s]};
    wire [8:0] step_v = $signed(diff) >>> (2 * filt_q);
    assign active[s] = |(ch_touch & slider_mask_q[s]);
    assign flt_nx[s] = (filt_q == 2'h0) ? coord[s] : flt_q[s] + step_v[7:0];
    assign rel[s] = held_q[s] && !active[s];
    assign tap_ok[s] = rel[s] && timer_q[s] <= tap_to_q
      && abs_diff(last_raw_q[s], start_raw_q[s]) <= (swipe_thr_q >> 1);
    assign swp_ok[s] = rel[s] && timer_q[s] < swipe_to_q
      && abs_diff(flt_q[s], start_flt_q[s]) > swipe_thr_q;
  end

  // Touch start latches origin; release judges the gesture
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      held_q <= 2'h0;
      tap_det <= 2'h0;
      swipe_det <= 2'h0;
      for (int s = 0; s < 2; s++)
      begin
        timer_q[s] <= 8'h00;
        start_raw_q[s] <= 8'h00;
        start_flt_q[s] <= 8'h00;
        last_raw_q[s] <= 8'h00;
        flt_q[s] <= 8'h00;
      end
    end
    else
    begin
      held_q <= active;
      tap_det <= tap_ok;
      swipe_det <= swp_ok;
      for (int s = 0; s < 2; s++)
      begin
        if (active[s] && !held_q[s])
        begin
          timer_q[s] <= 8'h00;
          start_raw_q[s] <= coord[s];
          start_flt_q[s] <= coord[s];
          last_raw_q[s] <= coord[s];
          flt_q[s] <= coord[s];
        end
        else if (active[s])
        begin
          if (step && timer_q[s] != tgs_pkg::TIMER_MAX)
            timer_q[s] <= timer_q[s] + 8'h01;
          last_raw_q[s] <= coord[s];
          if (sample_tick)
            flt_q[s] <= flt_nx[s];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Host link control and read port
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      window_end <= 1'b0;
      stop_det_dis <= 1'b0;
      ro_write_en <= 1'b0;
      sleep_in_win <= 1'b0;
      rd_data <= 16'h0000;
    end
    else
    begin
      window_end <= end_cmd;
      stop_det_dis <= link_ctrl_q[tgs_pkg::STOP_DIS_BIT];
      ro_write_en <= link_ctrl_q[tgs_pkg::RO_DIS_BIT];
      sleep_in_win <= link_ctrl_q[tgs_pkg::SLEEP_BIT];
      if (rd_en)
        rd_data <= rd_mux;
    end
  end

endmodule : tgs_ctrl

// ---- verif/tgs_ctrl_properties.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port-level checker for the settings block
// ------------------------------------------------------------
module tgs_ctrl_chk (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic wr_en, // Write strobe
  input wire logic [7:0] reg_addr, // Word address
  input wire logic [15:0] wr_data, // Write word
  input wire logic [7:0] ref_assoc, // Reference group
  input wire logic [7:0] ch_prox, // Proximity states
  input wire logic [7:0] ch_touch, // Touch states
  input wire logic [7:0] ch_change, // Changed channels
  input wire logic [7:0] avg_out_band, // Outside band
  input wire logic [7:0] reseed_req, // Reseed pulses
  input wire logic [7:0] retune_req, // Retune pulses
  input wire logic ref_avg_freeze, // Reference hold
  input wire logic [7:0] track_sub_en, // Subtract enables
  input wire logic [7:0] event_rpt, // Reported events
  input wire logic window_end, // Window close pulse
  input wire logic stop_det_dis // Stop ignore level
);
  // Decodes used by the properties below
  wire logic lw = wr_en && reg_addr == 8'hf2;
  wire logic [7:0] act = ref_assoc & (ch_prox | ch_touch);
  wire logic [7:0] rl = reseed_req & avg_out_band;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_END_PULSE: assert property (lw && wr_data[7] |=> window_end)
    else $error("window_end missing after end write");
  AST_END_CAUSE: assert property (window_end |-> $past(lw && wr_data[7]))
    else $error("window_end without end write");
  // Level passes the stored byte, then the output flop: two edges of lag
  AST_STOP_VAL: assert property (lw |=> ##1 stop_det_dis == $past(wr_data[6], 2))
    else $error("stop_det_dis differs from written bit");
  AST_STOP_HOLD: assert property (!$past(lw, 2) |-> $stable(stop_det_dis))
    else $error("stop_det_dis moved without write");
  AST_AUTO_RETUNE: assert property (|rl |=> (retune_req & $past(rl)) == $past(rl))
    else $error("out of band reseed did not retune");
  AST_FREEZE_CAUSE: assert property (ref_avg_freeze |-> $past(|act))
    else $error("reference hold without active channel");
  AST_SUB_SUBSET: assert property (|track_sub_en |-> (track_sub_en & ~$past(act)) == 8'h00)
    else $error("subtract on idle channel");
  AST_EVT_CAUSE: assert property (|event_rpt |-> (event_rpt & ~$past(ch_change)) == 8'h00)
    else $error("event on unchanged channel");
endmodule : tgs_ctrl_chk
bind tgs_ctrl tgs_ctrl_chk chk_u (.sys_clk, .reset, .wr_en, .reg_addr, .wr_data, .ref_assoc,
  .ch_prox, .ch_touch, .ch_change, .avg_out_band, .reseed_req, .retune_req, .ref_avg_freeze,
  .track_sub_en, .event_rpt, .window_end, .stop_det_dis);

// ---- verif/tgs_host_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: window level and retune command bit
// ------------------------------------------------------------
module tgs_host_model (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic close_req, // Bench ends window
  input wire logic retune_set, // Bench asks retune
  input wire logic window_end, // Device ended window
  output logic win_open, // Window open level
  output logic retune_cmd // Retune command bit
);
  // Window drops for one cycle, so the device sees a clean close
  always_ff @(posedge sys_clk)
  begin
    win_open <= !reset && !close_req && !window_end;
    retune_cmd <= !reset && (retune_set || (retune_cmd && !close_req && !window_end));
  end
endmodule : tgs_host_model

// ---- verif/touch_global_settings_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module touch_global_settings_ctrl_tb_top;
  logic sys_clk, reset, wr_en, rd_en, sample_tick, ref_trig, close_req, retune_set;
  logic win_open, retune_cmd, ref_avg_freeze, window_end, stop_det_dis, ro_write_en;
  logic sleep_in_win;
  logic [7:0] reg_addr, ref_assoc, ch_prox, ch_touch, ch_change, avg_out_band, coord0, coord1;
  logic [7:0] reseed_req, retune_req, track_sub_en, event_rpt, ch_deep;
  logic [15:0] wr_data, rd_data, rv;
  logic [1:0] tap_det, swipe_det, tg, sg;
  int err_count, checked, cyc, n;
  logic [7:0] ra [7] = '{8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'hf2, 8'h90};
  logic [15:0] wd [5] = '{16'hffff, 16'h1280, 16'h0f03, 16'h0402, 16'hffff};
  logic [15:0] we [5] = '{16'h9b00, 16'h0080, 16'h0f03, 16'h0402, 16'h0000};
  logic [7:0] ec [7] = '{8'h01, 8'h01, 8'h80, 8'h80, 8'h81, 8'h81, 8'h02};
  logic [7:0] ep [7] = '{8'h00, 8'h80, 8'h01, 8'h00, 8'h81, 8'h00, 8'h80};
  logic [7:0] ee [7] = '{8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h02};
  int gh [7] = '{2, 2, 2, 30, 30, 2, 2};
  logic [7:0] gc [7] = '{8'h24, 8'h2c, 8'h40, 8'h20, 8'h40, 8'h40, 8'h24};
  logic [1:0] gx [7] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b00, 2'b00, 2'b10};

  // Short tick keeps gesture windows to a few dozen cycles
  tgs_ctrl #(.TICK_CYC(4)) dut_u (.sys_clk, .reset, .wr_en, .rd_en, .reg_addr, .wr_data,
    .rd_data, .win_open, .retune_cmd, .sample_tick, .ref_trig, .ref_assoc, .ch_prox,
    .ch_touch, .ch_deep, .ch_change, .avg_out_band, .coord0, .coord1, .reseed_req,
    .retune_req, .ref_avg_freeze, .track_sub_en, .event_rpt, .tap_det, .swipe_det,
    .window_end, .stop_det_dis, .ro_write_en, .sleep_in_win);
  tgs_host_model host_u (.sys_clk, .reset, .close_req, .retune_set, .window_end,
    .win_open, .retune_cmd);

  // Clock and hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      final_report();
    end
  end

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    reg_addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    rv = rd_data;
  endtask : rd
  // Link control write keeps the internal flags as read
  task lnk(input logic [3:0] b);
    rd(8'hf2);
    wr(8'hf2, {8'h00, b, rv[3:0]});
  endtask : lnk
  task trig(input logic [7:0] exp);
    @(posedge sys_clk);
    ref_trig <= 1'b1;
    @(posedge sys_clk);
    ref_trig <= 1'b0;
    #1;
    chk("reseed_req", {8'h00, exp}, {8'h00, reseed_req});
  endtask : trig
  task final_report;
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    {wr_en, rd_en, sample_tick, ref_trig, close_req, retune_set} = 6'h00;
    {reg_addr, ref_assoc, ch_prox, ch_touch, ch_change, coord0, coord1} = 56'h0;
    avg_out_band = 8'h04;
    ch_deep = 8'h00;
    wr_data = 16'h0000;
    reset = 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk("reset value", 16'h0000, rv);
    end
    foreach (wd[i])
    begin
      wr(ra[i == 4 ? 6 : i], wd[i]);
      rd(ra[i == 4 ? 6 : i]);
      chk("readback", we[i], rv);
    end
    wr(8'h87, 16'h0000);
    wr(8'h8b, 16'h0510);
    lnk(4'h8);
    chk("reseed_req", 16'h0005, {8'h00, reseed_req});
    chk("window_end", 16'h0001, {15'h0, window_end});
    @(posedge sys_clk);
    #1;
    chk("auto retune", 16'h0004, {8'h00, retune_req});
    rd(8'hf2);
    chk("end bit kept", 16'h0080, rv);
    // Levels follow the stored byte one edge after the write lands
    lnk(4'h7);
    @(posedge sys_clk) #1;
    chk("link levels", 16'h0007, {13'h0, stop_det_dis, ro_write_en, sleep_in_win});
    lnk(4'h0);
    @(posedge sys_clk) #1;
    chk("link levels", 16'h0000, {13'h0, stop_det_dis, ro_write_en, sleep_in_win});
    wr(8'h8b, 16'h0a10);
    @(posedge sys_clk);
    retune_set <= 1'b1;
    @(posedge sys_clk);
    retune_set <= 1'b0;
    close_req <= 1'b1;
    @(posedge sys_clk);
    close_req <= 1'b0;
    for (n = 0; n < 4 && retune_req === 8'h00; n++) @(posedge sys_clk) #1;
    chk("retune_req", 16'h000a, {8'h00, retune_req});
    chk("reseed_req", 16'h0000, {8'h00, reseed_req});
    ref_assoc <= 8'h01;
    foreach (ec[i])
    begin
      @(posedge sys_clk);
      ch_change <= ec[i];
      ch_prox <= ep[i];
      sample_tick <= 1'b1;
      @(posedge sys_clk);
      sample_tick <= 1'b0;
      ch_change <= 8'h00;
      #1;
      chk("event_rpt", {8'h00, ee[i]}, {8'h00, event_rpt});
    end
    // Level 11 would reseed anything, so only tracking can block the trigger
    wr(8'h87, 16'h9800);
    ch_prox <= 8'h01;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("freeze", 16'h0001, {15'h0, ref_avg_freeze});
    chk("track_sub_en", 16'h0001, {8'h00, track_sub_en});
    trig(8'h00);
    ch_prox <= 8'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("idle freeze", 16'h0000, {15'h0, ref_avg_freeze});
    chk("idle sub", 16'h0000, {8'h00, track_sub_en});
    ch_prox <= 8'h01;
    for (n = 0; n < 4; n++)
    begin
      wr(8'h87, {3'b000, n[1:0], 11'h000});
      trig(n == 0 ? 8'h00 : 8'h01);
    end
    // Deep touch splits level 10 from level 11
    ch_deep <= 8'h01;
    wr(8'h87, 16'h1000);
    trig(8'h00);
    wr(8'h87, 16'h1800);
    trig(8'h01);
    ch_deep <= 8'h00;
    ch_prox <= 8'h00;
    wr(8'h87, 16'h0000);
    wr(8'h89, 16'h0003);
    wr(8'h8b, 16'h0010);
    foreach (gh[i])
    begin
      // Strongest filter for the last two: swipe sees no move, tap stays raw
      if (i == 5)
        wr(8'h87, 16'h0300);
      @(posedge sys_clk);
      sample_tick <= 1'b1;
      ch_touch <= 8'h01;
      coord0 <= 8'h20;
      @(posedge sys_clk);
      coord0 <= gc[i];
      repeat (gh[i]) @(posedge sys_clk);
      ch_touch <= 8'h00;
      tg = 2'b00;
      sg = 2'b00;
      repeat (5) @(posedge sys_clk) #1 {tg, sg} = {tg | tap_det, sg | swipe_det};
      sample_tick <= 1'b0;
      chk("tap swipe", {12'h0, gx[i], 2'b00}, {12'h0, tg[0], sg[0], tg[1], sg[1]});
    end
    final_report();
  end
endmodule : touch_global_settings_ctrl_tb_top
